// ===== src/pll_source_routing_control.sv
// pll source routing and digital pll control behind a wishbone slave
// Summary of operation
// - bypass bit feeds distribution without vco divider
// - source bit zero selects external clock input
// - power field 01 holds pll powered down
// - power field 00 runs pll with settings
// - polarity bit swaps pump up and down in normal pump mode
// - settings take effect only on update write
// - detector compares reference and feedback divider edges
// - detector commands pump up or pump down
// - two-bit field sets antibacklash pulse width
// - pump mode: hiz, normal, forced up, down
// - pump current in eight equal steps
// - source bit one selects internal vco
// - vco divider field sets ratio two to six
// - calibration starts on bit set plus update with power field 00
`timescale 1ns/100ps
module pll_source_routing_control
#(
    parameter int CAL_EDGES = pll_route_pkg::CAL_REF_EDGES
)
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [pll_route_pkg::ADR_W-1:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic refDivOut,
    input wire logic fbDivOut,
    input wire logic clkInTick,
    input wire logic vcoTick,
    output logic distTick,
    output logic pllPowerDown,
    output logic pumpUp,
    output logic pumpDown,
    output logic pumpHiZ,
    output logic [2:0] pumpCurrentCode,
    output logic [1:0] ablWidthCode,
    output logic vcoCalBusy
);
    import pll_route_pkg::*;

    logic [1:0] rstPipeQ;
    logic rstSyncN;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            rstPipeQ <= 2'b00;
        else
            rstPipeQ <= {rstPipeQ[0], 1'b1};
    end
    assign rstSyncN = rstPipeQ[1];

    // wishbone slave: ack one cycle after request, write at ack edge
    logic ackQ;
    logic [31:0] datQ;
    cfg_t shadowQ;
    cfg_t shadowD;
    cfg_t activeQ;
    wire busReq = cyc_i & stb_i;
    wire [IDX_W-1:0] regIdx = adr_i[ADR_W-1:2];
    wire wrEn = busReq & we_i & ackQ & sel_i[0];
    wire [7:0] wrByte = dat_i[7:0];
    wire updWr = wrEn && regIdx == IDX_UPDATE && wrByte == UPDATE_KEY;
    logic [7:0] rdByte;
    logic [7:0] statusByte;

    always_ff @(posedge mclk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            ackQ <= 1'b0;
            datQ <= 32'h0;
        end
        else
        begin
            ackQ <= busReq & ~ackQ;
            if (busReq & ~ackQ)
                datQ <= {24'h0, rdByte};
        end
    end
    assign ack_o = ackQ;
    assign dat_o = datQ;

    // unmapped and update addresses read as zero
    always_comb
    begin
        if (regIdx == IDX_PLL_CTRL)
            rdByte = shadowQ.pllCtrl;
        else if (regIdx == IDX_ABL)
            rdByte = shadowQ.abl;
        else if (regIdx == IDX_CAL)
            rdByte = shadowQ.cal;
        else if (regIdx == IDX_PUMP_CUR)
            rdByte = shadowQ.pumpCur;
        else if (regIdx == IDX_VCO_DIV)
            rdByte = shadowQ.vcoDiv;
        else if (regIdx == IDX_DIST_SRC)
            rdByte = shadowQ.distSrc;
        else if (regIdx == IDX_STATUS)
            rdByte = statusByte;
        else
            rdByte = 8'h00;
    end

    always_comb
    begin
        shadowD = shadowQ;
        if (wrEn)
        begin
            if (regIdx == IDX_PLL_CTRL)
                shadowD.pllCtrl = wrByte;
            else if (regIdx == IDX_ABL)
                shadowD.abl = wrByte;
            else if (regIdx == IDX_CAL)
                shadowD.cal = wrByte;
            else if (regIdx == IDX_PUMP_CUR)
                shadowD.pumpCur = wrByte;
            else if (regIdx == IDX_VCO_DIV)
                shadowD.vcoDiv = wrByte;
            else if (regIdx == IDX_DIST_SRC)
                shadowD.distSrc = wrByte;
        end
    end

    // written values wait in the shadow set until the update write
    always_ff @(posedge mclk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            shadowQ <= CFG_RESET;
            activeQ <= CFG_RESET;
        end
        else
        begin
            shadowQ <= shadowD;
            if (updWr)
                activeQ <= shadowQ;
        end
    end

    a_update_applies: assert property (@(posedge mclk) disable iff (!rstSyncN)
        updWr |=> activeQ == $past(shadowQ))
        else $error("update write did not copy the pending settings");
    a_no_early_apply: assert property (@(posedge mclk) disable iff (!rstSyncN)
        !updWr |=> activeQ == $past(activeQ))
        else $error("settings changed without an update write");

    // decoded active fields
    wire pllOn = activeQ.pllCtrl[PWR_LO +: 2] == PWR_NORMAL;
    wire [2:0] cpMode = activeQ.pllCtrl[CPM_LO +: 3];
    wire polNeg = activeQ.pllCtrl[POL_BIT];
    wire srcVco = activeQ.distSrc[SRC_BIT];
    wire divBypass = activeQ.distSrc[BYP_BIT];
    // any power code but normal keeps the pll off
    assign pllPowerDown = ~pllOn;
    assign pumpCurrentCode = activeQ.pumpCur[2:0];
    assign ablWidthCode = activeQ.abl[1:0];

    // source routing and vco divider, ticks mark source clock edges
    logic [2:0] divCntQ;
    logic distTickQ;
    wire srcTick = srcVco ? vcoTick : clkInTick;
    wire [2:0] divCode = activeQ.vcoDiv[2:0];
    // codes above four clamp to the largest ratio
    wire [2:0] divLast = (divCode > 3'd4) ? 3'd5 : divCode + 3'd1;
    wire divWrap = divCntQ >= divLast;

    always_ff @(posedge mclk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            divCntQ <= 3'd0;
            distTickQ <= 1'b0;
        end
        else
        begin
            if (srcTick)
                divCntQ <= divWrap ? 3'd0 : divCntQ + 3'd1;
            distTickQ <= divBypass ? srcTick : srcTick & divWrap;
        end
    end
    assign distTick = distTickQ;

    a_bypass_ext: assert property (@(posedge mclk) disable iff (!rstSyncN)
        (divBypass && !srcVco && !updWr) |=> distTick == $past(clkInTick))
        else $error("bypassed clock input not passed to distribution");
    a_bypass_vco: assert property (@(posedge mclk) disable iff (!rstSyncN)
        (divBypass && srcVco && !updWr) |=> distTick == $past(vcoTick))
        else $error("bypassed vco not passed to distribution");

    // phase frequency detector on divider output edges
    logic refPrevQ;
    logic fbPrevQ;
    logic upQ;
    logic dnQ;
    logic [2:0] ablCntQ;
    wire refRise = refDivOut & ~refPrevQ;
    wire fbRise = fbDivOut & ~fbPrevQ;
    wire bothOn = upQ & dnQ;
    // both pulses overlap for code plus one cycles to avoid a dead zone
    wire ablEnd = bothOn && ablCntQ == {1'b0, ablWidthCode};

    always_ff @(posedge mclk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            refPrevQ <= 1'b0;
            fbPrevQ <= 1'b0;
            upQ <= 1'b0;
            dnQ <= 1'b0;
            ablCntQ <= 3'd0;
        end
        else
        begin
            refPrevQ <= refDivOut;
            fbPrevQ <= fbDivOut;
            if (!pllOn || ablEnd)
            begin
                upQ <= 1'b0;
                dnQ <= 1'b0;
                ablCntQ <= 3'd0;
            end
            else
            begin
                upQ <= upQ | refRise;
                dnQ <= dnQ | fbRise;
                ablCntQ <= bothOn ? ablCntQ + 3'd1 : 3'd0;
            end
        end
    end

    a_ref_sets_up: assert property (@(posedge mclk) disable iff (!rstSyncN)
        (pllOn && refRise && !bothOn && !updWr) |=> upQ)
        else $error("reference edge did not raise the up request");
    a_abl_width: assert property (@(posedge mclk) disable iff (!rstSyncN)
        (pllOn && $rose(bothOn) && $stable(activeQ)) |-> ##[0:4] !(upQ && dnQ))
        else $error("antibacklash overlap longer than allowed");

    // charge pump command from mode, polarity and detector
    logic pumpUpQ;
    logic pumpDnQ;
    logic pumpUpD;
    logic pumpDnD;

    always_comb
    begin
        pumpUpD = 1'b0;
        pumpDnD = 1'b0;
        if (pllOn)
        begin
            case (cpMode)
                CP_FORCE_UP:
                    pumpUpD = 1'b1;
                CP_FORCE_DOWN:
                    pumpDnD = 1'b1;
                CP_NORMAL:
                begin
                    pumpUpD = polNeg ? dnQ : upQ;
                    pumpDnD = polNeg ? upQ : dnQ;
                end
                default:
                begin
                    pumpUpD = 1'b0;
                    pumpDnD = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            pumpUpQ <= 1'b0;
            pumpDnQ <= 1'b0;
        end
        else
        begin
            pumpUpQ <= pumpUpD;
            pumpDnQ <= pumpDnD;
        end
    end
    assign pumpUp = pumpUpQ;
    assign pumpDown = pumpDnQ;
    // hiz also covers power-down, holding the loop voltage
    assign pumpHiZ = ~pumpUpQ & ~pumpDnQ;

    a_powerdown_quiet: assert property (@(posedge mclk) disable iff (!rstSyncN)
        (!pllOn && !updWr) |=> !pumpUp && !pumpDown)
        else $error("pump active while pll powered down");
    a_forced_up: assert property (@(posedge mclk) disable iff (!rstSyncN)
        (pllOn && cpMode == CP_FORCE_UP && !updWr) |=> pumpUp && !pumpDown)
        else $error("forced pump up not applied");
    a_neg_polarity: assert property (@(posedge mclk) disable iff (!rstSyncN)
        (pllOn && cpMode == CP_NORMAL && polNeg && !updWr) |=> pumpUp == $past(dnQ))
        else $error("negative polarity did not swap pump direction");

    // vco calibration counts reference edges while the pll runs
    cal_state_t calStateQ;
    logic [15:0] calCntQ;
    wire calStart = updWr & shadowQ.cal[CAL_BIT] & ~activeQ.cal[CAL_BIT]
        & (shadowQ.pllCtrl[PWR_LO +: 2] == PWR_NORMAL);
    wire calRestart = updWr & ~shadowQ.cal[CAL_BIT];

    always_ff @(posedge mclk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            calStateQ <= CAL_IDLE;
            calCntQ <= 16'h0;
        end
        else
        begin
            case (calStateQ)
                CAL_IDLE:
                    if (calStart)
                    begin
                        calStateQ <= CAL_RUN;
                        calCntQ <= 16'h0;
                    end
                CAL_RUN:
                    if (!pllOn)
                        calStateQ <= CAL_IDLE;
                    else if (refRise)
                    begin
                        calCntQ <= calCntQ + 16'h1;
                        if (calCntQ == 16'(CAL_EDGES - 1))
                            calStateQ <= CAL_DONE;
                    end
                CAL_DONE:
                    if (calRestart)
                        calStateQ <= CAL_IDLE;
                default:
                    calStateQ <= CAL_IDLE;
            endcase
        end
    end
    assign vcoCalBusy = calStateQ == CAL_RUN;

    a_cal_start: assert property (@(posedge mclk) disable iff (!rstSyncN)
        (calStateQ == CAL_IDLE && calStart) |=> vcoCalBusy)
        else $error("calibration did not start on update");

    always_comb
    begin
        statusByte = 8'h00;
        statusByte[ST_CAL_BUSY] = vcoCalBusy;
        statusByte[ST_CAL_DONE] = calStateQ == CAL_DONE;
        statusByte[ST_PLL_ON] = pllOn;
        statusByte[ST_UP] = pumpUpQ;
        statusByte[ST_DN] = pumpDnQ;
        statusByte[ST_SRC_VCO] = srcVco;
    end
endmodule

// ===== inc/pll_route_pkg.sv
// constants, types and register map for the pll source routing control
package pll_route_pkg;
    localparam int ADR_W = 12;
    localparam int IDX_W = 10;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_PLL_CTRL = 10'h010;
    localparam logic [9:0] IDX_ABL = 10'h017;
    localparam logic [9:0] IDX_CAL = 10'h018;
    localparam logic [9:0] IDX_PUMP_CUR = 10'h020;
    localparam logic [9:0] IDX_STATUS = 10'h021;
    localparam logic [9:0] IDX_VCO_DIV = 10'h1e0;
    localparam logic [9:0] IDX_DIST_SRC = 10'h1e1;
    localparam logic [9:0] IDX_UPDATE = 10'h232;
    localparam logic [7:0] UPDATE_KEY = 8'h01;
    // field positions
    localparam int PWR_LO = 0;
    localparam int CPM_LO = 4;
    localparam int POL_BIT = 7;
    localparam int BYP_BIT = 0;
    localparam int SRC_BIT = 1;
    localparam int CAL_BIT = 0;
    localparam int ST_CAL_BUSY = 0;
    localparam int ST_CAL_DONE = 1;
    localparam int ST_PLL_ON = 2;
    localparam int ST_UP = 3;
    localparam int ST_DN = 4;
    localparam int ST_SRC_VCO = 5;
    // values after reset
    localparam logic [7:0] RST_PLL_CTRL = 8'h01;
    localparam logic [7:0] RST_ABL = 8'h00;
    localparam logic [7:0] RST_CAL = 8'h00;
    localparam logic [7:0] RST_PUMP_CUR = 8'h00;
    localparam logic [7:0] RST_VCO_DIV = 8'h02;
    localparam logic [7:0] RST_DIST_SRC = 8'h00;
    localparam int CAL_REF_EDGES = 64;

    typedef enum logic [1:0] {
        PWR_NORMAL = 2'b00,
        PWR_ASYNC_DOWN = 2'b01
    } pwr_mode_t;

    typedef enum logic [2:0] {
        CP_HIZ = 3'b000,
        CP_FORCE_UP = 3'b001,
        CP_FORCE_DOWN = 3'b010,
        CP_NORMAL = 3'b011
    } cp_mode_t;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN = 2'b01,
        CAL_DONE = 2'b10
    } cal_state_t;

    typedef struct packed {
        logic [7:0] pllCtrl;
        logic [7:0] abl;
        logic [7:0] cal;
        logic [7:0] pumpCur;
        logic [7:0] vcoDiv;
        logic [7:0] distSrc;
    } cfg_t;

    localparam cfg_t CFG_RESET = '{RST_PLL_CTRL, RST_ABL, RST_CAL, RST_PUMP_CUR, RST_VCO_DIV, RST_DIST_SRC};
endpackage

// ===== verification/pll_far_side.sv
// behavioural model of the reference, feedback divider and clock sources
`timescale 1ns/100ps
module pll_far_side
(
    input wire logic mclk,
    input wire logic refRun,
    input wire logic fbRun,
    input wire logic srcRun,
    output logic refDivOut,
    output logic fbDivOut,
    output logic clkInTick,
    output logic vcoTick
);
    logic [3:0] phase_q = 4'h0;

    // a stopped reference divider holds its level, a stopped feedback divider falls back to zero
    always_ff @(posedge mclk)
    begin
        phase_q <= phase_q + 4'h1;
        refDivOut <= refRun ? phase_q[2] : refDivOut;
        fbDivOut <= fbRun ? phase_q[2] : 1'b0;
        clkInTick <= srcRun && (phase_q[1:0] == 2'h0);
        vcoTick <= srcRun && phase_q[0];
    end
endmodule

// ===== verification/pll_source_routing_control_tb.sv
// self-checking bench for the pll source routing control
`timescale 1ns/100ps
module pll_source_routing_control_tb;
    import pll_route_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] datI = 32'h00000000;
    logic [31:0] datO;
    logic ack;
    logic refRun = 1'b1;
    logic fbRun = 1'b0;
    logic srcRun = 1'b1;
    logic refDivOut, fbDivOut, clkInTick, vcoTick, distTick, pllPowerDown;
    logic pumpUp, pumpDown, pumpHiZ, vcoCalBusy;
    logic [2:0] pumpCurrentCode;
    logic [1:0] ablWidthCode;
    logic useVco = 1'b0;
    logic counting = 1'b0;
    logic [31:0] rd;
    int failures = 0;
    int checked = 0;
    int srcCnt = 0;
    int distCnt = 0;
    int bothCnt = 0;

    pll_source_routing_control #(.CAL_EDGES(4)) pll_source_routing_control_i (.mclk(mclk), .rstn(rstn),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(datI), .sel_i(4'hf), .dat_o(datO),
        .ack_o(ack), .refDivOut(refDivOut), .fbDivOut(fbDivOut), .clkInTick(clkInTick), .vcoTick(vcoTick),
        .distTick(distTick), .pllPowerDown(pllPowerDown), .pumpUp(pumpUp), .pumpDown(pumpDown),
        .pumpHiZ(pumpHiZ), .pumpCurrentCode(pumpCurrentCode), .ablWidthCode(ablWidthCode),
        .vcoCalBusy(vcoCalBusy));

    pll_far_side pll_far_side_i (.mclk(mclk), .refRun(refRun), .fbRun(fbRun), .srcRun(srcRun),
        .refDivOut(refDivOut), .fbDivOut(fbDivOut), .clkInTick(clkInTick), .vcoTick(vcoTick));

    initial
    begin
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        if (counting)
        begin
            srcCnt += int'(useVco ? vcoTick : clkInTick);
            distCnt += int'(distTick);
            bothCnt += int'(pumpUp && pumpDown);
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // one classic cycle; the wait on ack is bounded so a dead slave cannot hang us
    task automatic wb(input logic [9:0] idx, input logic w, input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        datI <= {24'h000000, d};
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50)
            chk(32'h0, 32'h1, "no ack");
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        wb(idx, 1'b1, d, rd);
    endtask

    task automatic rdchk(input logic [9:0] idx, input logic [31:0] mask, input logic [31:0] exp, input string what);
        wb(idx, 1'b0, 8'h00, rd);
        chk(rd & mask, exp, what);
    endtask

    task automatic upd();
        wr(IDX_UPDATE, UPDATE_KEY);
        repeat (2) @(negedge mclk);
    endtask

    task automatic t_reset();
        chk({31'h0, pllPowerDown}, 32'h1, "power down after reset");
        rdchk(IDX_PLL_CTRL, 32'hffffffff, {24'h0, RST_PLL_CTRL}, "pll ctrl reset");
        rdchk(IDX_VCO_DIV, 32'hffffffff, {24'h0, RST_VCO_DIV}, "vco div reset");
        rdchk(IDX_DIST_SRC, 32'hffffffff, {24'h0, RST_DIST_SRC}, "dist src reset");
        wr(10'h3ff, 8'h5a);
        rdchk(10'h3ff, 32'hffffffff, 32'h0, "unmapped read");
        $display("test reset values done");
    endtask

    task automatic t_update();
        wr(IDX_PLL_CTRL, 8'h10);
        wr(IDX_PUMP_CUR, 8'h07);
        wr(IDX_ABL, 8'h03);
        wr(IDX_DIST_SRC, 8'h02);
        @(negedge mclk);
        chk({31'h0, pllPowerDown}, 32'h1, "pending config leaked");
        wr(IDX_UPDATE, 8'h02);
        repeat (2) @(negedge mclk);
        chk({31'h0, pllPowerDown}, 32'h1, "wrong update key applied");
        upd();
        chk({31'h0, pllPowerDown}, 32'h0, "pll not on");
        chk({29'h0, pumpUp, pumpDown, pumpHiZ}, 32'h4, "forced up");
        chk({29'h0, pumpCurrentCode}, 32'h7, "pump current top step");
        chk({30'h0, ablWidthCode}, 32'h3, "antibacklash code");
        rdchk(IDX_STATUS, 32'h20, 32'h20, "source vco with pll");
        rdchk(IDX_PLL_CTRL, 32'hffffffff, 32'h10, "pll ctrl readback");
        $display("test update gating done");
    endtask

    task automatic t_pump();
        logic [7:0] ctrl [6] = '{8'h20, 8'h00, 8'h30, 8'hb0, 8'h70, 8'h32};
        logic [2:0] exp [6] = '{3'h2, 3'h1, 3'h4, 3'h2, 3'h1, 3'h1};
        // fb stopped, so only the reference edge sets the detector
        for (int i = 0; i < 6; i++)
        begin
            wr(IDX_PLL_CTRL, ctrl[i]);
            upd();
            repeat (20) @(negedge mclk);
            chk({29'h0, pumpUp, pumpDown, pumpHiZ}, {29'h0, exp[i]}, "pump mode");
        end
        wr(IDX_PLL_CTRL, 8'h11);
        upd();
        chk({30'h0, pllPowerDown, pumpUp}, 32'h2, "async power down");
        $display("test pump modes done");
    endtask

    // both dividers run in step, so every period opens one overlap window
    task automatic t_abl();
        logic [1:0] codes [2] = '{2'h0, 2'h3};
        wr(IDX_PLL_CTRL, 8'h30);
        fbRun <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            wr(IDX_ABL, {6'h00, codes[i]});
            upd();
            repeat (16) @(negedge mclk);
            bothCnt = 0;
            counting = 1'b1;
            repeat (80) @(negedge mclk);
            counting = 1'b0;
            chk(bothCnt, 10 * (codes[i] + 1), "antibacklash overlap");
        end
        fbRun <= 1'b0;
        $display("test antibacklash done");
    endtask

    task automatic dist_case(input logic [7:0] src, input logic [7:0] div, input int ratio);
        int err;
        wr(IDX_VCO_DIV, div);
        wr(IDX_DIST_SRC, src);
        upd();
        useVco = src[1];
        repeat (10) @(negedge mclk);
        srcCnt = 0;
        distCnt = 0;
        counting = 1'b1;
        repeat (240) @(negedge mclk);
        counting = 1'b0;
        err = distCnt * ratio - srcCnt;
        chk({31'h0, (srcCnt > 0 && err <= ratio && err >= -ratio)}, 32'h1, "distribution tick ratio");
    endtask

    task automatic t_route();
        dist_case(8'h01, 8'h00, 1);
        dist_case(8'h03, 8'h00, 1);
        for (int c = 0; c < 5; c++)
            dist_case(8'h02, 8'(c), c + 2);
        dist_case(8'h00, 8'h02, 4);
        $display("test routing done");
    endtask

    task automatic t_cal();
        int n;
        refRun = 1'b1;
        wr(IDX_PLL_CTRL, 8'h30);
        wr(IDX_CAL, 8'h01);
        upd();
        chk({31'h0, vcoCalBusy}, 32'h1, "calibration not started");
        n = 0;
        while (vcoCalBusy === 1'b1 && n < 200)
        begin
            @(negedge mclk);
            n++;
        end
        chk({31'h0, (n >= 16 && n < 200)}, 32'h1, "calibration length");
        rdchk(IDX_STATUS, 32'h3, 32'h2, "calibration done");
        wr(IDX_CAL, 8'h00);
        upd();
        rdchk(IDX_STATUS, 32'h3, 32'h0, "calibration back to idle");
        $display("test calibration done");
    endtask

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        t_reset();
        t_update();
        t_pump();
        t_abl();
        t_route();
        t_cal();
        wrap_up();
    end

    initial
    begin
        #300us;
        failures++;
        $display("Error at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule
